/* src/mdcc_host.sv */
// Notes on behaviour
// R1: Gate input stays high until the command-to-gate interval has elapsed.
// R2: After mode read, gate stays high through latency, skew, burst, postamble.
// R3: Reference voltage change via mode write waits its settling time.
// R4: Calibration start needs its gate interval before gate may fall.
// R5: Clock change or stop only when bank activity and intervals are done.
// R6: Clock kept unchanged at least four device clocks after gate falls.
// R7: Two good clock cycles are given before the gate rises again.
// R8: Stopped clock with gate low: true low, complement high.
// R9: High-gate clock change waits for all accesses and recovery.
// R10: Chip select held low during high-gate frequency change.
// R11: High-gate stop holds select low, true low, complement high.
// R12: After high-gate change, wait two periods plus exit latency.
// R13: After frequency change software may rewrite latency settings.
// R14: Unspecified operation needs power cycle and full initialization.
// R15: Multi-purpose: select high, lines 0-4 low, line 5 bit 6.
// R16: Precharge and refresh patterns, all-bank flag, bank on second edge.
// R17: Second column command carries column bits 8 and 2-7.
// R18: Commands take two device cycles; deselect takes one.
// R19: Column first parts are followed at once by the second column command.
// R20: Activate first part is followed at once by its second part.
// R21: Mode write first part is followed at once by its second part.
// R22: Activate row bits and mode write address and operand placement.
// R23: Reserved first-edge patterns are never issued by this controller.
`timescale 1ns/1ps
`default_nettype none
module mdcc_host
    import mdcc_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RSTN,
    input  wire logic [7:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [31:0] RDATA,
    output logic             CK_T,
    output logic             CK_C,
    output logic             CKE,
    output logic             CS,
    output logic      [5:0]  CA
);
    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_s1_q;
    logic rst_n;
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        MDCC_IDLE, MDCC_E1, MDCC_E2, MDCC_E3, MDCC_E4
    } mdcc_seq_t;

    mdcc_seq_t       seq_q;
    logic [31:0]     arg_q;
    logic [31:0]     timing_q;
    logic [2:0]      clkctl_q;
    logic            div_q;
    logic [TMR_W-1:0] hold_q;
    logic [TMR_W-1:0] low_q;
    logic [TMR_W-1:0] ready_q;
    logic            gate_q;
    logic            stop_q;
    logic            cs_q;
    logic [5:0]      ca_q;
    logic            issued_q;
    logic [35:0]     cmd_q;
    logic            head_ok_q;
    logic [35:0]     head;
    logic            q_empty;
    logic            q_full;
    logic            pop;
    logic            bus_busy;

    // Control bits: 0 = request gate low, 1 = stop clock, 2 = high-gate stop.
    wire req_low   = clkctl_q[0];
    wire req_stop  = clkctl_q[1];
    wire req_hstop = clkctl_q[2];

    mdcc_cmd_queue u_queue (
        .clk       (CLK),
        .rst_n     (rst_n),
        .push      (WR && ADDR == ADDR_CMD),
        .push_data ({WDATA[3:0], arg_q}),
        .pop       (pop),
        .head      (head),
        .empty     (q_empty),
        .full      (q_full)
    );

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            arg_q    <= 32'h0;
            timing_q <= TIMING_RST;
            clkctl_q <= 3'h0;
        end else if (WR) begin
            unique case (ADDR)
                ADDR_ARG:    arg_q    <= WDATA;
                ADDR_TIMING: timing_q <= WDATA;
                ADDR_CLKCTL: clkctl_q <= WDATA[2:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            RDATA <= 32'h0;
        end else if (RD) begin
            unique case (ADDR)
                ADDR_ARG:    RDATA <= arg_q;
                ADDR_TIMING: RDATA <= timing_q;
                ADDR_CLKCTL: RDATA <= {29'h0, clkctl_q};
                ADDR_STATUS: RDATA <= {26'h0, (ready_q == '0), stop_q,
                                       gate_q, q_full, !q_empty,
                                       bus_busy};
                default:     RDATA <= 32'h0;
            endcase
        end else begin
            RDATA <= 32'h0;
        end
    end

    // ------------------------------------------------------------------
    // Device clock
    // ------------------------------------------------------------------
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 1'b0;
        end else if (stop_q) begin
            div_q <= 1'b0;
        end else begin
            div_q <= !div_q;
        end
    end

    // R8 stop level
    // R11 stop level
    assign CK_T = div_q;
    assign CK_C = !div_q;
    wire   ck_edge = (div_q == 1'b1) && !stop_q;

    // ------------------------------------------------------------------
    // Command issue: one edge per device clock rise
    // ------------------------------------------------------------------
    wire [35:0] cur  = bus_busy ? cmd_q : head;
    wire [3:0]  op   = cur[35:32];
    wire [31:0] a    = cur[31:0];
    wire        mode_reg_read  = (op == MDCC_OP_MRR);
    assign bus_busy = (seq_q != MDCC_IDLE);
    wire can_issue = !q_empty && gate_q && !stop_q && (ready_q == '0)
                     && !req_low && !req_hstop && head_ok_q;
    assign pop = ck_edge && !bus_busy && can_issue;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            issued_q  <= 1'b0;
            head_ok_q <= 1'b0;
        end else begin
            issued_q  <= pop;
            head_ok_q <= !q_empty;
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            seq_q <= MDCC_IDLE;
            cs_q  <= 1'b0;
            ca_q  <= 6'h0;
            cmd_q <= 36'h0;
        end else if (ck_edge) begin
            unique case (seq_q)
                MDCC_IDLE: begin
                    cs_q <= 1'b0;
                    ca_q <= 6'h0;
                    if (pop) begin
                        seq_q <= MDCC_E2;
                        cmd_q <= head;
                        cs_q  <= 1'b1;
                        unique case (op)
                            // R15 mpc first edge
                            MDCC_OP_MPC: ca_q <= {a[6], PAT_MPC};
                            // R16 precharge refresh
                            MDCC_OP_PRE: ca_q <= {a[8], PAT_PRE};
                            MDCC_OP_REF: ca_q <= {a[8], PAT_REF};
                            // R22 row placement
                            MDCC_OP_ACT: ca_q <= {a[15:12], PAT_ACT1};
                            MDCC_OP_MRW: ca_q <= {a[15], PAT_MRW1};
                            MDCC_OP_MRR: ca_q <= {1'b0, PAT_MRR1};
                            MDCC_OP_RD:  ca_q <= {a[9], PAT_RD1};
                            MDCC_OP_WR:  ca_q <= {a[9], PAT_WR1};
                            default:     ca_q <= {1'b0, PAT_MPC};
                        endcase
                    end
                end
                MDCC_E2: begin
                    // R18 second edge
                    cs_q <= 1'b0;
                    unique case (op)
                        MDCC_OP_MPC: ca_q <= a[5:0];
                        MDCC_OP_PRE, MDCC_OP_REF: ca_q <= {3'h0, a[2:0]};
                        MDCC_OP_ACT: ca_q <= {a[11:10], 1'b0, a[2:0]};
                        MDCC_OP_MRW: ca_q <= a[21:16];
                        MDCC_OP_MRR: ca_q <= a[21:16];
                        default:     ca_q <= {a[10], a[9], 1'b0, a[2:0]};
                    endcase
                    seq_q <= (op == MDCC_OP_PRE || op == MDCC_OP_REF)
                             ? MDCC_IDLE : MDCC_E3;
                end
                MDCC_E3: begin
                    // R19 column follow-on
                    // R20 activate follow-on
                    // R21 mode write follow-on
                    cs_q  <= 1'b1;
                    seq_q <= MDCC_E4;
                    unique case (op)
                        MDCC_OP_ACT: ca_q <= {a[9:6], PAT_ACT2};
                        MDCC_OP_MRW: ca_q <= {a[14], PAT_MRW2};
                        // R17 column second
                        default:     ca_q <= {a[31], PAT_CAS2};
                    endcase
                    if (op == MDCC_OP_MPC) begin
                        cs_q  <= 1'b0;
                        ca_q  <= 6'h0;
                        seq_q <= MDCC_IDLE;
                    end
                end
                MDCC_E4: begin
                    cs_q  <= 1'b0;
                    seq_q <= MDCC_IDLE;
                    unique case (op)
                        MDCC_OP_ACT: ca_q <= a[5:0];
                        MDCC_OP_MRW: ca_q <= a[13:8];
                        default:     ca_q <= a[30:25];
                    endcase
                end
                default: seq_q <= MDCC_IDLE;
            endcase
        end
    end

    assign CS = cs_q;
    assign CA = ca_q;

    // ------------------------------------------------------------------
    // Gate and clock control
    // ------------------------------------------------------------------
    // Software programs the hold needed after each command in the timing
    // register; mode reads get latency, skew, burst and postamble there.
    logic [TMR_W-1:0] hold_load;
    always_comb begin
        hold_load = TMR_W'(CMD_TO_GATE_CYC);
        if (mode_reg_read) begin
            hold_load = timing_q[TMR_W-1:0];
        end else if (timing_q[TMR_W+15:16] > hold_load) begin
            hold_load = timing_q[TMR_W+15:16];
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            hold_q <= '0;
        end else if (pop) begin
            // R1 hold gate
            // R2 read hold
            // R3 vref settle
            // R4 calibration hold
            // R9 access done
            hold_q <= hold_load;
        end else if (hold_q != '0 && !bus_busy && !issued_q) begin
            hold_q <= hold_q - TMR_W'(1);
        end
    end

    wire quiet = !bus_busy && !issued_q && (hold_q == '0);

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            gate_q <= 1'b1;
            stop_q <= 1'b0;
            low_q  <= '0;
        end else if (gate_q) begin
            low_q <= '0;
            // R5 quiet before change
            if (req_low && quiet) begin
                gate_q <= 1'b0;
            end
            // R10 select low
            if (req_hstop && quiet && !cs_q && ck_edge) begin
                stop_q <= 1'b1;
            end else if (!req_hstop && stop_q) begin
                stop_q <= 1'b0;
            end
        end else begin
            if (low_q != '1) begin
                low_q <= low_q + TMR_W'(1);
            end
            // R6 four clocks
            if (req_stop && ck_edge &&
                low_q >= TMR_W'(GATE_LOW_HOLD_CK * CK_DIV)) begin
                stop_q <= 1'b1;
            end else if (!req_stop && stop_q) begin
                stop_q <= 1'b0;
                low_q  <= TMR_W'(GATE_LOW_HOLD_CK * CK_DIV);
            end
            // R7 clocks before rise
            if (!req_low && !stop_q && !req_stop &&
                low_q >= TMR_W'((GATE_LOW_HOLD_CK + GATE_HIGH_PRE_CK)
                                * CK_DIV)) begin
                gate_q <= 1'b1;
            end
        end
    end

    // R12 ready wait
    // R13 software rewrites
    // R14 restart after fault
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ready_q <= '0;
        end else if (stop_q || !gate_q) begin
            ready_q <= TMR_W'(GATE_HIGH_PRE_CK * CK_DIV + PD_EXIT_CYC);
        end else if (ready_q != '0) begin
            ready_q <= ready_q - TMR_W'(1);
        end
    end

    assign CKE = gate_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!rst_n);

    a_gate_hold_cmd: assert property ( // R1
        pop |-> CKE [*8]) else $error("gate fell during command hold");
    a_stop_clock_low: assert property ( // R8
        stop_q |-> (!CK_T && CK_C)) else $error("stopped clock not parked");
    a_stop_cs_low: assert property ( // R11
        (stop_q && CKE) |-> !CS) else $error("select high during stop");
    a_low_hold_four: assert property ( // R6
        $fell(CKE) |-> !stop_q [*8]) else $error("clock changed too soon");
    a_rise_after_run: assert property ( // R7
        $rose(CKE) |-> !$past(stop_q, 4)) else $error("gate rose too soon");
    a_act_pairs: assert property ( // R20
        (ck_edge && seq_q == MDCC_E3 && op == MDCC_OP_ACT)
        |=> CA[1:0] == PAT_ACT2) else $error("activate split");
    a_cas_follows: assert property ( // R19
        (ck_edge && seq_q == MDCC_E3 && (op == MDCC_OP_RD || mode_reg_read))
        |=> CA[4:0] == PAT_CAS2) else $error("column split");
    a_mrw_pairs: assert property ( // R21
        (ck_edge && seq_q == MDCC_E3 && op == MDCC_OP_MRW)
        |=> CA[4:0] == PAT_MRW2) else $error("mode write split");
    a_ready_wait: assert property ( // R12
        $fell(stop_q) |-> !pop [*4]) else $error("command before ready");
    a_quiet_change: assert property ( // R5
        $fell(CKE) |-> !$past(bus_busy)) else $error("gate fell mid command");

    c_cmd: cover property (pop ##[1:20] !bus_busy);
    c_low: cover property ($fell(CKE) ##[1:100] $rose(CKE));
    c_stop: cover property ($rose(stop_q) ##[1:100] $fell(stop_q));
endmodule
`default_nettype wire

/* pkg/mdcc_pkg.sv */
package mdcc_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS        = 8000;
    // Device clock is CLK divided by two; one device period is two CLKs.
    localparam int CK_DIV               = 2;
    localparam int GATE_LOW_HOLD_CK     = 4;
    localparam int GATE_HIGH_PRE_CK     = 2;
    localparam int CMD_TO_GATE_NS       = 10;
    localparam int CMD_TO_GATE_CYC      =
        (CMD_TO_GATE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PD_EXIT_NS           = 8;
    localparam int PD_EXIT_CYC          =
        (PD_EXIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int TMR_W                = 10;

    // ------------------------------------------------------------------
    // Software registers (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CMD     = 8'h00;
    localparam logic [7:0] ADDR_ARG     = 8'h04;
    localparam logic [7:0] ADDR_CLKCTL  = 8'h08;
    localparam logic [7:0] ADDR_STATUS  = 8'h0c;
    localparam logic [7:0] ADDR_TIMING  = 8'h10;
    localparam logic [7:0] ADDR_QDEPTH  = 8'h14;
    localparam logic [31:0] TIMING_RST  = 32'h0000_0010;
    localparam int QDEPTH               = 4;

    // ------------------------------------------------------------------
    // Command codes written to the command register
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        MDCC_OP_MPC  = 4'h0,
        MDCC_OP_PRE  = 4'h1,
        MDCC_OP_REF  = 4'h2,
        MDCC_OP_ACT  = 4'h3,
        MDCC_OP_MRW  = 4'h4,
        MDCC_OP_MRR  = 4'h5,
        MDCC_OP_RD   = 4'h6,
        MDCC_OP_WR   = 4'h7
    } mdcc_op_t;

    // First-edge patterns on lines 0..4 (bit 0 is line 0).
    localparam logic [4:0] PAT_MPC      = 5'b00000;
    localparam logic [4:0] PAT_PRE      = 5'b10000;
    localparam logic [4:0] PAT_REF      = 5'b01000;
    localparam logic [4:0] PAT_WR1      = 5'b00100;
    localparam logic [4:0] PAT_RD1      = 5'b00010;
    localparam logic [4:0] PAT_CAS2     = 5'b10010;
    localparam logic [4:0] PAT_MRW1     = 5'b00110;
    localparam logic [4:0] PAT_MRW2     = 5'b10110;
    localparam logic [4:0] PAT_MRR1     = 5'b01110;
    localparam logic [1:0] PAT_ACT1     = 2'b01;
    localparam logic [1:0] PAT_ACT2     = 2'b11;

endpackage

/* src/mdcc_cmd_queue.sv */
`timescale 1ns/1ps
`default_nettype none
module mdcc_cmd_queue
    import mdcc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        push,
    input  wire logic [35:0] push_data,
    input  wire logic        pop,
    output logic      [35:0] head,
    output logic             empty,
    output logic             full
);
    logic [35:0] mem_q [QDEPTH];
    logic [1:0]  wp_q;
    logic [1:0]  rp_q;
    logic [2:0]  cnt_q;

    assign empty = (cnt_q == 3'h0);
    assign full  = (cnt_q == 3'(QDEPTH));

    always_ff @(posedge clk) begin
        if (push && !full) begin
            mem_q[wp_q] <= push_data;
        end
    end

    // Head comes from a register so the issuer sees a stable word.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            head <= 36'h0;
        end else begin
            head <= mem_q[(pop && !empty) ? rp_q + 2'h1 : rp_q];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q  <= 2'h0;
            rp_q  <= 2'h0;
            cnt_q <= 3'h0;
        end else begin
            if (push && !full) begin
                wp_q <= wp_q + 2'h1;
            end
            if (pop && !empty) begin
                rp_q <= rp_q + 2'h1;
            end
            cnt_q <= cnt_q + 3'((push && !full) ? 1 : 0)
                           - 3'((pop && !empty) ? 1 : 0);
        end
    end
endmodule
`default_nettype wire

/* tb/mdcc_dram_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Behavioural device: decodes two-edge commands and counts faults.
// ----------------------------------------------------------------------
module mdcc_dram_model
    import mdcc_pkg::*;
(
    input  wire logic       ck_t,
    input  wire logic       ck_c,
    input  wire logic       cke,
    input  wire logic       cs,
    input  wire logic [5:0] ca,
    output logic      [7:0] faults
);
    logic [11:0] seen[$];
    logic [5:0]  first_q;
    logic        second_q = 1'b0;
    int          need_q   = 0;
    int          fall_n   = 0;
    int          run_n    = 99;
    realtime     last_t   = 0.0;
    realtime     cmd_t    = 0.0;
    realtime     run_t    = 0.0;

    initial faults = 8'h00;

    // clock pair complementary; the level a stop holds is not checked here.
    always @(ck_t or ck_c) #1 if (ck_c !== ~ck_t) faults++;

    always @(posedge ck_t) begin
        // A gap of more than two and a half periods means the clock was held.
        if ($realtime - last_t > 40.0) begin
            // stop only when idle and, with gate low, four cycles after it fell.
            if (need_q != 0 || (!cke && fall_n < GATE_LOW_HOLD_CK))
                faults++;
            run_n = 0;
            run_t = $realtime;
        end
        last_t = $realtime;
        fall_n++;
        run_n++;
        if (second_q) begin
            if (cs !== 1'b0) faults++;
            seen.push_back({first_q, ca});
            second_q = 1'b0;
        end else if (cs === 1'b1) begin
            // no command before two periods plus exit latency.
            if ($realtime - run_t < 2 * CK_DIV * 8 + PD_EXIT_NS) faults++;
            case (need_q)
                1: if (ca[4:0] !== PAT_CAS2) faults++;
                2: if (ca[1:0] !== PAT_ACT2) faults++;
                3: if (ca[4:0] !== PAT_MRW2) faults++;
                default: if (ca[4:0] inside {PAT_CAS2, PAT_MRW2} ||
                             ca[1:0] === PAT_ACT2) faults++;
            endcase
            if (ca[4:0] inside {5'b11100, 5'b01010, 5'b11010, 5'b11110})
                faults++;
            // work out which second part is owed.
            if (ca[0])
                need_q = (need_q == 2) ? 0 : 2;
            else if (ca[4:0] inside {PAT_WR1, PAT_RD1, PAT_MRR1})
                need_q = 1;
            else if (ca[4:0] === PAT_MRW1)
                need_q = 3;
            else
                need_q = 0;
            first_q = ca;
            second_q = 1'b1;
            cmd_t = $realtime;
        end
    end

    // gate falls only after the command-to-gate interval.
    always @(negedge cke) begin
        if ($realtime - cmd_t < CMD_TO_GATE_NS) faults++;
        fall_n = 0;
    end

    // two good clocks before the gate rises.
    always @(posedge cke) if (run_n < GATE_HIGH_PRE_CK) faults++;

    // select stays low while the clock is held.
    always @(posedge cs) if ($realtime - last_t > 20.0) faults++;
endmodule
`default_nettype wire

/* tb/mdcc_host_test.sv */
`timescale 1ns/1ps
`default_nettype none
module mdcc_host_test
    import mdcc_pkg::*;
;
    logic        clk   = 1'b0;
    logic        rstn  = 1'b0;
    logic [7:0]  addr  = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr    = 1'b0;
    logic        rd    = 1'b0;
    logic [31:0] rdata;
    logic        ck_t;
    logic        ck_c;
    logic        cke;
    logic        cs;
    logic [5:0]  ca;
    logic [7:0]  faults;
    int          miscompares = 0;
    int          n_tests     = 0;

    initial forever #4 clk = ~clk;

    mdcc_host mdcc_host_inst (
        .CLK   (clk),
        .RSTN  (rstn),
        .ADDR  (addr),
        .WDATA (wdata),
        .WR    (wr),
        .RD    (rd),
        .RDATA (rdata),
        .CK_T  (ck_t),
        .CK_C  (ck_c),
        .CKE   (cke),
        .CS    (cs),
        .CA    (ca)
    );

    mdcc_dram_model mdcc_dram_model_inst (
        .ck_t   (ck_t),
        .ck_c   (ck_c),
        .cke    (cke),
        .cs     (cs),
        .ca     (ca),
        .faults (faults)
    );

    // ------------------------------------------------------------------
    // Shared bus and compare tasks
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        if (miscompares == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask

    task automatic issue(input mdcc_op_t op, input logic [31:0] arg);
        wr_reg(ADDR_ARG, arg);
        wr_reg(ADDR_CMD, {28'h0, op});
    endtask

    // Takes the next decoded command pair; masks hide don't-care lines.
    task automatic pair(input logic [5:0] f, input logic [5:0] fm,
                        input logic [5:0] s, input logic [5:0] sm);
        logic [11:0] p;
        p = 'x;
        for (int n = 0; n < 400 && mdcc_dram_model_inst.seen.size() == 0;
             n++)
            @(posedge clk);
        if (mdcc_dram_model_inst.seen.size() != 0)
            p = mdcc_dram_model_inst.seen.pop_front();
        check("first edge", {26'h0, p[11:6] & fm}, {26'h0, f & fm});
        check("second edge", {26'h0, p[5:0] & sm}, {26'h0, s & sm});
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        logic [31:0] d;
        check("idle pins", {29'h0, cke, cs, ck_c ^ ck_t}, 32'h5);
        rd_reg(ADDR_STATUS, d);
        check("status gate", {31'h0, d[3]}, 32'h1);
        rd_reg(ADDR_TIMING, d);
        check("timing", d, TIMING_RST);
    endtask

    task automatic t_bank();
        issue(MDCC_OP_PRE, 32'h0000_0105);
        pair({1'b1, PAT_PRE}, 6'h3f, 6'h05, 6'h07);
        issue(MDCC_OP_REF, 32'h0000_0003);
        pair({1'b0, PAT_REF}, 6'h3f, 6'h03, 6'h07);
    endtask

    task automatic t_mpc();
        logic [6:0] v [2] = '{7'h55, 7'h2a};
        for (int i = 0; i < 2; i++) begin
            issue(MDCC_OP_MPC, {25'h0, v[i]});
            pair({v[i][6], 5'h0}, 6'h3f, v[i][5:0], 6'h3f);
        end
    endtask

    task automatic t_act();
        logic [15:0] r;
        r = 16'habcd;
        issue(MDCC_OP_ACT, {16'h0, r});
        pair({r[15:12], PAT_ACT1}, 6'h3f, {r[11:10], 4'h0}, 6'h30);
        pair({r[9:6], PAT_ACT2}, 6'h3f, r[5:0], 6'h3f);
    endtask

    task automatic t_mrw();
        logic [5:0] a;
        logic [7:0] v;
        a = 6'h2a;
        v = 8'h96;
        issue(MDCC_OP_MRW, {10'h0, a, v, 8'h0});
        pair({v[7], PAT_MRW1}, 6'h3f, a, 6'h3f);
        pair({v[6], PAT_MRW2}, 6'h3f, v[5:0], 6'h3f);
    endtask

    task automatic t_column();
        mdcc_op_t    ops [3] = '{MDCC_OP_RD, MDCC_OP_WR, MDCC_OP_MRR};
        logic [4:0]  pats [3] = '{PAT_RD1, PAT_WR1, PAT_MRR1};
        logic [5:0]  m;
        logic [31:0] a;
        a = {7'h6c, 14'h0, 2'b11, 6'h0, 3'h1};
        for (int i = 0; i < 3; i++) begin
            m = (i < 2) ? 6'h3f : 6'h00;
            issue(ops[i], a);
            pair({1'b0, pats[i]}, 6'h1f, {a[10:9], 1'b0, a[2:0]}, m & 6'h37);
            pair({a[31], PAT_CAS2}, 6'h3f, a[30:25], m);
        end
    endtask

    task automatic t_clock();
        logic [31:0] ctl [3] = '{32'h1, 32'h3, 32'h4};
        logic [31:0] d;
        for (int i = 0; i < 3; i++) begin
            wr_reg(ADDR_CLKCTL, ctl[i]);
            repeat (80) @(posedge clk);
            rd_reg(ADDR_STATUS, d);
            check("gate pin", {31'h0, cke}, {31'h0, ctl[i] == 32'h4});
            check("stopped", {31'h0, d[4]}, {31'h0, ctl[i] > 32'h1});
            if (ctl[i] > 32'h1)
                check("held pins", {29'h0, ck_t, ck_c, cs}, 32'h2);
            wr_reg(ADDR_CLKCTL, 32'h0);
            for (int n = 0; n < 200 && cke !== 1'b1; n++)
                @(posedge clk);
            check("gate back", {31'h0, cke}, 32'h1);
            issue(MDCC_OP_REF, 32'h0000_0100);
            pair({1'b1, PAT_REF}, 6'h3f, 6'h00, 6'h00);
        end
    endtask

    task automatic t_queue();
        logic [31:0] d;
        wr_reg(ADDR_CLKCTL, 32'h4);
        repeat (80) @(posedge clk);
        wr_reg(ADDR_ARG, 32'h0000_0100);
        @(posedge clk);
        addr <= ADDR_CMD;
        wdata <= {28'h0, MDCC_OP_PRE};
        wr <= 1'b1;
        repeat (6) @(posedge clk);
        wr <= 1'b0;
        rd_reg(ADDR_STATUS, d);
        check("queue flags", {30'h0, d[2:1]}, 32'h3);
        wr_reg(ADDR_CLKCTL, 32'h0);
        for (int i = 0; i < 4; i++)
            pair({1'b1, PAT_PRE}, 6'h3f, 6'h00, 6'h00);
        repeat (200) @(posedge clk);
        check("extra", 32'(mdcc_dram_model_inst.seen.size()), 32'h0);
        rd_reg(8'hfc, d);
        check("unmapped", d, 32'h0);
    endtask

    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        t_reset();
        t_bank();
        t_mpc();
        t_act();
        t_mrw();
        t_column();
        t_clock();
        t_queue();
        repeat (20) @(posedge clk);
        check("device faults", {24'h0, faults}, 32'h0);
        conclude();
    end

    // The scenarios need under a thousand cycles; this bound cuts a hang.
    initial begin
        repeat (40000) @(posedge clk);
        miscompares++;
        conclude();
    end
endmodule
`default_nettype wire
